//--- core/dio_pkg.sv
package dio_pkg;
    localparam int unsigned CLK_HZ        = 125_000_000;
    localparam int unsigned NPINS         = 7;
    localparam int unsigned MIN_LOW_NS    = 30_000;
    localparam int unsigned MIN_LOW_CYC   = (MIN_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned CNT_W         = 32;

    // register byte offsets
    localparam logic [7:0] A_FUNC   = 8'h00; // 2 bits per pin
    localparam logic [7:0] A_INV    = 8'h04;
    localparam logic [7:0] A_OVAL   = 8'h08;
    localparam logic [7:0] A_PWMEN  = 8'h0c;
    localparam logic [7:0] A_PERIOD = 8'h10;
    localparam logic [7:0] A_LOWCYC = 8'h14;
    localparam logic [7:0] A_INVAL  = 8'h18;
    localparam logic [7:0] A_STAT   = 8'h1c;
    localparam logic [7:0] A_MASK   = 8'h20;
    localparam logic [7:0] A_PROT   = 8'h24;

    localparam logic [1:0] FN_DEFAULT = 2'h0;
    localparam logic [1:0] FN_INPUT   = 2'h1;
    localparam logic [1:0] FN_OUTPUT  = 2'h2;

    localparam int unsigned ST_CLEAR  = 0; // status bit: protection cleared by pin 1
    localparam int unsigned ST_PULSE  = 1; // status bit: re-enable pulse emitted
    localparam int unsigned ST_W      = 2;

    localparam logic [31:0] PERIOD_RST = 32'h0001312d; // 1600 Hz at 125 MHz
    localparam logic [31:0] LOWCYC_RST = 32'h0000f424; // 80 %, i.e. 0.5 ms low

    typedef enum logic [1:0] { EM_IDLE, EM_LOW } dio_emit_t;

    typedef struct packed {
        logic [2*NPINS-1:0] func;
        logic [NPINS-1:0]   inv;
        logic [NPINS-1:0]   oval;
        logic [NPINS-1:0]   pwmen;
        logic [31:0]        period;
        logic [31:0]        lowcyc;
        logic [ST_W-1:0]    stat;
        logic [ST_W-1:0]    mask;
    } dio_cfg_t;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } dio_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } dio_axi_rsp_t;
endpackage : dio_pkg

//--- core/dio_pin_ctrl.sv
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module dio_pin_ctrl #(
    parameter int unsigned MIN_LOW = dio_pkg::MIN_LOW_CYC
) (
    input  wire logic                       aclk,        // 125 MHz clock
    input  wire logic                       aresetn,     // sync reset, active low
    input  wire dio_pkg::dio_axi_req_t      axi_req,     // axi4-lite master side
    output      dio_pkg::dio_axi_rsp_t      axi_rsp,     // axi4-lite slave side
    input  wire logic [dio_pkg::NPINS-1:0]  pin_i,       // pin level seen on the wire
    output      logic [dio_pkg::NPINS-1:0]  pin_o,       // pin drive level
    output      logic [dio_pkg::NPINS-1:0]  pin_oe,      // high while driving the pin
    input  wire logic                       prot_active, // protection state is active
    input  wire logic                       out_enable,  // power output enable
    output      logic                       prot_clear,  // one-cycle clear request
    output      logic                       irq          // level interrupt
);
    import dio_pkg::*;

    initial begin
        if (MIN_LOW < 1 || MIN_LOW >= 2**(CNT_W-1)) begin
            $error("MIN_LOW out of range");
        end
    end

    typedef struct packed {
        dio_cfg_t           cfg;
        logic [NPINS-1:0]   s1;
        logic [NPINS-1:0]   s2;
        logic [NPINS-1:0]   lvl;
        logic [CNT_W-1:0]   lowcnt;
        logic [31:0]        pwmcnt;
        logic               oen_prev;
        logic               released;
        dio_emit_t          emit;
        logic [CNT_W-1:0]   emitcnt;
        logic               clr;
        logic               aw_got;
        logic [7:0]         awaddr;
        logic               w_got;
        logic [31:0]        wdata;
        logic [3:0]         wstrb;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               rvalid;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
    } dio_state_t;

    dio_state_t s_q;
    dio_state_t s_d;

    // ------------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------------
    logic [NPINS-1:0] logic_val;
    logic             pwm_low;

    assign pwm_low = (s_q.pwmcnt < s_q.cfg.lowcyc);

    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            logic_val[i] = 1'b0;
            pin_oe[i]    = 1'b0;
            pin_o[i]     = 1'b1;
            if (s_q.cfg.func[2*i +: 2] == FN_OUTPUT) begin
                pin_oe[i]    = 1'b1;
                // logic 1 means the active (low) phase
                logic_val[i] = s_q.cfg.pwmen[i] ? pwm_low : s_q.cfg.oval[i];
                pin_o[i]     = logic_val[i] ^~ s_q.cfg.inv[i];
            end else if (i == 0 && s_q.cfg.func[1:0] == FN_DEFAULT) begin
                // pin 1 only drives during its pulse; otherwise the line is left to the partner
                pin_oe[i] = (s_q.emit == EM_LOW);
                pin_o[i]  = ~(s_q.emit == EM_LOW) ^ s_q.cfg.inv[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // bus, clear and interrupt outputs
    // ------------------------------------------------------------------
    logic wr_fire;
    logic rd_fire;

    assign axi_rsp.awready = ~s_q.aw_got & ~s_q.bvalid;
    assign axi_rsp.wready  = ~s_q.w_got & ~s_q.bvalid;
    assign axi_rsp.bvalid  = s_q.bvalid;
    assign axi_rsp.bresp   = s_q.bresp;
    assign axi_rsp.arready = ~s_q.rvalid;
    assign axi_rsp.rvalid  = s_q.rvalid;
    assign axi_rsp.rdata   = s_q.rdata;
    assign axi_rsp.rresp   = s_q.rresp;
    assign wr_fire         = s_q.aw_got & s_q.w_got & ~s_q.bvalid;
    assign rd_fire         = axi_req.arvalid & ~s_q.rvalid;
    assign prot_clear      = s_q.clr;
    assign irq             = |(s_q.cfg.stat & s_q.cfg.mask);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    always_comb begin
        logic [NPINS-1:0] pin_lvl;
        logic [ST_W-1:0]  ev;
        logic [31:0]      wv;
        logic             p1_clr_mode;
        logic             rd_hit;
        pin_lvl     = '0;
        ev          = '0;
        wv          = '0;
        rd_hit      = 1'b0;
        s_d         = s_q;
        s_d.clr     = 1'b0;
        p1_clr_mode = (s_q.cfg.func[1:0] == FN_DEFAULT);

        // input path: two-flop synchroniser, then polarity
        s_d.s1  = pin_i;
        s_d.s2  = s_q.s1;
        pin_lvl = s_q.s2 ^ s_q.cfg.inv;
        s_d.lvl = pin_lvl;

        // pin 1 low-time measurement; pulse accepted at the rising edge that ends it
        if (!pin_lvl[0]) begin
            if (s_q.lowcnt != '1) begin
                s_d.lowcnt = s_q.lowcnt + 1'b1;
            end
        end else begin
            s_d.lowcnt = '0;
            if (p1_clr_mode && prot_active && s_q.emit == EM_IDLE
                && s_q.lowcnt >= CNT_W'(MIN_LOW)) begin
                s_d.clr       = 1'b1;
                ev[ST_CLEAR]  = 1'b1;
            end
        end

        // pwm period counter
        if (s_q.pwmcnt + 32'h1 >= s_q.cfg.period) begin
            s_d.pwmcnt = '0;
        end else begin
            s_d.pwmcnt = s_q.pwmcnt + 32'h1;
        end

        // re-enable pulse on pin 1
        s_d.oen_prev = out_enable;
        // the clear is issued while protection is still up, so it is remembered
        // until the re-enable pulse starts
        if (s_q.clr) begin
            s_d.released = 1'b1;
        end
        case (s_q.emit)
            EM_IDLE: begin
                if (p1_clr_mode && s_q.released && !prot_active
                    && out_enable && !s_q.oen_prev) begin
                    s_d.emit     = EM_LOW;
                    s_d.emitcnt  = '0;
                    s_d.released = 1'b0;
                    ev[ST_PULSE] = 1'b1;
                end
            end
            EM_LOW: begin
                s_d.emitcnt = s_q.emitcnt + 1'b1;
                if (s_q.emitcnt + 1'b1 >= CNT_W'(MIN_LOW)) begin
                    s_d.emit = EM_IDLE;
                end
            end
            default: s_d.emit = EM_IDLE;
        endcase

        // axi write channel
        if (axi_req.awvalid && axi_rsp.awready) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && axi_rsp.wready) begin
            s_d.w_got = 1'b1;
            s_d.wdata = axi_req.wdata;
            s_d.wstrb = axi_req.wstrb;
        end
        if (wr_fire) begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = 2'b00;
            wv         = s_q.wdata;
            case (s_q.awaddr)
                A_FUNC:   s_d.cfg.func   = merge(32'(s_q.cfg.func), wv, s_q.wstrb)
                                           [2*NPINS-1:0];
                A_INV:    s_d.cfg.inv    = merge(32'(s_q.cfg.inv), wv, s_q.wstrb)[NPINS-1:0];
                A_OVAL:   s_d.cfg.oval   = merge(32'(s_q.cfg.oval), wv, s_q.wstrb)[NPINS-1:0];
                A_PWMEN:  s_d.cfg.pwmen  = merge(32'(s_q.cfg.pwmen), wv, s_q.wstrb)[NPINS-1:0];
                A_PERIOD: s_d.cfg.period = merge(s_q.cfg.period, wv, s_q.wstrb);
                A_LOWCYC: s_d.cfg.lowcyc = merge(s_q.cfg.lowcyc, wv, s_q.wstrb);
                A_MASK:   s_d.cfg.mask   = merge(32'(s_q.cfg.mask), wv, s_q.wstrb)[ST_W-1:0];
                A_INVAL, A_STAT, A_PROT: ;
                default:  s_d.bresp = 2'b10;
            endcase
        end
        if (s_q.bvalid && axi_req.bready) begin
            s_d.bvalid = 1'b0;
        end

        // axi read channel
        if (rd_fire) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = 2'b00;
            s_d.rdata  = '0;
            case (axi_req.araddr)
                A_FUNC:   s_d.rdata = 32'(s_q.cfg.func);
                A_INV:    s_d.rdata = 32'(s_q.cfg.inv);
                A_OVAL:   s_d.rdata = 32'(s_q.cfg.oval);
                A_PWMEN:  s_d.rdata = 32'(s_q.cfg.pwmen);
                A_PERIOD: s_d.rdata = s_q.cfg.period;
                A_LOWCYC: s_d.rdata = s_q.cfg.lowcyc;
                A_INVAL:  s_d.rdata = 32'(s_q.lvl);
                A_STAT: begin
                    s_d.rdata = 32'(s_q.cfg.stat);
                    rd_hit    = 1'b1;
                end
                A_MASK:   s_d.rdata = 32'(s_q.cfg.mask);
                A_PROT:   s_d.rdata = {30'h0, s_q.emit == EM_LOW, prot_active};
                default:  s_d.rresp = 2'b10;
            endcase
        end
        if (s_q.rvalid && axi_req.rready) begin
            s_d.rvalid = 1'b0;
        end

        // sticky status: read clears, a new event in the same cycle survives
        s_d.cfg.stat = (rd_hit ? '0 : s_q.cfg.stat) | ev;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q            <= '0;
            s_q.s1         <= '1;
            s_q.s2         <= '1;
            s_q.lvl        <= '1;
            s_q.cfg.period <= PERIOD_RST;
            s_q.cfg.lowcyc <= LOWCYC_RST;
            s_q.emit       <= EM_IDLE;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : dio_pin_ctrl

//--- bench/dio_pin_ctrl_props.sv
`timescale 1ns/1ps
module dio_pin_ctrl_props #(
    parameter int unsigned MIN_LOW = 20
) (
    input wire logic                      aclk,        // clock
    input wire logic                      aresetn,     // sync reset
    input wire dio_pkg::dio_axi_req_t     axi_req,     // bus request
    input wire dio_pkg::dio_axi_rsp_t     axi_rsp,     // bus answer
    input wire logic [dio_pkg::NPINS-1:0] pin_i,       // wire level
    input wire logic [dio_pkg::NPINS-1:0] pin_o,       // drive level
    input wire logic [dio_pkg::NPINS-1:0] pin_oe,      // drive enable
    input wire logic                      prot_active, // protection on
    input wire logic                      out_enable,  // output on
    input wire logic                      prot_clear,  // clear request
    input wire logic                      irq          // interrupt
);
    import dio_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // the clear width is judged on the wire, so a slip in the sync stage shows; the emitted width on the drive
    logic [31:0] in_run_q;
    logic [31:0] in_len_q;
    logic [31:0] dr_run_q;
    logic        dr_low;
    assign dr_low = pin_oe[0] & ~pin_o[0];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_run_q <= 32'h0;
            in_len_q <= 32'h0;
            dr_run_q <= 32'h0;
        end else begin
            in_run_q <= pin_i[0] ? 32'h0 : in_run_q + 32'h1;
            dr_run_q <= dr_low ? dr_run_q + 32'h1 : 32'h0;
            if (pin_i[0] && in_run_q != 32'h0) begin
                in_len_q <= in_run_q;
            end
        end
    end
    a_reset_quiet: assert property ($rose(aresetn) |-> pin_oe == '0 && !irq && !prot_clear)
        else $error("outputs active after reset");
    a_clear_single: assert property (prot_clear |=> !prot_clear)
        else $error("clear request longer than one cycle");
    a_clear_width: assert property (prot_clear |-> in_len_q >= MIN_LOW)
        else $error("clear after a short low pulse");
    a_emit_width: assert property ($fell(dr_low) |-> dr_run_q >= MIN_LOW)
        else $error("emitted pulse too short");
    a_emit_cause: assert property ($rose(dr_low) |-> out_enable)
        else $error("pulse emitted without output enable");
    a_write_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
        && axi_rsp.wready |=> ##1 axi_rsp.bvalid)
        else $error("write answer late");
    a_bresp_hold: assert property (axi_rsp.bvalid && !axi_req.bready
        |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
        else $error("write answer dropped");
    a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
        else $error("read answer late");
    a_rdata_hold: assert property (axi_rsp.rvalid && !axi_req.rready
        |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read data dropped");
    c_clear: cover property (prot_clear);
    c_emit: cover property ($fell(dr_low));
    c_wait: cover property (axi_rsp.rvalid && !axi_req.rready);
endmodule : dio_pin_ctrl_props
bind dio_pin_ctrl dio_pin_ctrl_props #(.MIN_LOW(MIN_LOW)) u_props (
    .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe(pin_oe), .prot_active(prot_active), .out_enable(out_enable),
    .prot_clear(prot_clear), .irq(irq)
);

//--- bench/dio_ext_model.sv
`timescale 1ns/1ps
module dio_ext_model (
    input  wire logic                      aclk,      // clock
    input  wire logic [dio_pkg::NPINS-1:0] pin_o,     // device drive level
    input  wire logic [dio_pkg::NPINS-1:0] pin_oe,    // device drive enable
    input  wire logic [dio_pkg::NPINS-1:0] ext_oe,    // instrument drive enable
    input  wire logic [dio_pkg::NPINS-1:0] ext_lvl,   // instrument drive level
    output      logic [dio_pkg::NPINS-1:0] pin_i,     // resolved wire
    output      logic [7:0]                pulse_cnt, // pulses the device drives low on pin 1
    output      logic [31:0]               pulse_len  // low time of the last one
);
    import dio_pkg::*;
    logic [31:0] run;
    // a released pin floats to the pull-up level
    always_comb begin
        for (int k = 0; k < NPINS; k++) begin
            pin_i[k] = pin_oe[k] ? pin_o[k] : (ext_oe[k] ? ext_lvl[k] : 1'b1);
        end
    end
    initial begin
        pulse_cnt = 8'h0;
        pulse_len = 32'h0;
        run = 32'h0;
    end
    always @(posedge aclk) begin
        if (pin_oe[0] && !pin_o[0]) begin
            run <= run + 32'h1;
        end else if (run != 32'h0) begin
            pulse_cnt <= pulse_cnt + 8'h1;
            pulse_len <= run;
            run <= 32'h0;
        end
    end
endmodule : dio_ext_model

//--- bench/dio_pin_ctrl_tb.sv
`timescale 1ns/1ps
module dio_pin_ctrl_tb;
    import dio_pkg::*;
    localparam int unsigned ML = 20;
    logic aclk, aresetn, prot_active, out_enable, prot_clear, irq;
    dio_axi_req_t req;
    dio_axi_rsp_t rsp;
    logic [NPINS-1:0] pin_i, pin_o, pin_oe, ext_oe, ext_lvl;
    logic [7:0]  pcnt;
    logic [31:0] plen, rd;
    int error_cnt, tests_run, cyc, clr_cnt, n;
    dio_pin_ctrl #(.MIN_LOW(ML)) dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
        .axi_rsp(rsp), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
        .prot_active(prot_active), .out_enable(out_enable), .prot_clear(prot_clear), .irq(irq));
    dio_ext_model u_ext (.aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe), .ext_oe(ext_oe),
        .ext_lvl(ext_lvl), .pin_i(pin_i), .pulse_cnt(pcnt), .pulse_len(plen));
    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check
    // ready is raised late on purpose so the slave must hold its answer
    task automatic answer(input logic is_rd, output logic [1:0] r);
        @(posedge aclk);
        while ((is_rd ? rsp.rvalid : rsp.bvalid) !== 1'b1) @(posedge aclk);
        req.bready <= ~is_rd;
        req.rready <= is_rd;
        @(posedge aclk);
        rd = rsp.rdata;
        r = is_rd ? rsp.rresp : rsp.bresp;
        req.bready <= 1'b0;
        req.rready <= 1'b0;
    endtask : answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        logic [1:0] r;
        ta = 1'b0;
        tw = 1'b0;
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        while (!(ta && tw)) begin
            @(negedge aclk);
            ta = ta | (req.awvalid & rsp.awready);
            tw = tw | (req.wvalid & rsp.wready);
            @(posedge aclk);
            if (ta) req.awvalid <= 1'b0;
            if (tw) req.wvalid <= 1'b0;
        end
        answer(1'b0, r);
        check({30'h0, r}, 32'h0);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [1:0] r;
        req.arvalid <= 1'b1;
        req.araddr <= a;
        @(negedge aclk);
        while (rsp.arready !== 1'b1) @(negedge aclk);
        @(posedge aclk);
        req.arvalid <= 1'b0;
        answer(1'b1, r);
        check({30'h0, r}, {30'h0, er});
        if (er == 2'b00) check(rd, e);
    endtask : rdc
    task automatic pins(input logic [6:0] oe, input logic [6:0] o);
        @(negedge aclk);
        check({25'h0, pin_oe & 7'h7e}, {25'h0, oe});
        check({25'h0, pin_o & 7'h7e}, {25'h0, o});
        @(posedge aclk);
    endtask : pins
    task automatic pulse(input int w);
        ext_oe[0] <= 1'b1;
        ext_lvl[0] <= 1'b0;
        repeat (w) @(posedge aclk);
        ext_lvl[0] <= 1'b1;
        @(posedge aclk);
        ext_oe[0] <= 1'b0;
        repeat (10) @(posedge aclk);
    endtask : pulse
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // far more than the sequence needs, so a hung handshake ends the run
    always @(posedge aclk) begin
        cyc++;
        if (prot_clear === 1'b1) clr_cnt++;
        if (cyc == 5000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        {aresetn, prot_active, out_enable, ext_oe, ext_lvl} = '0;
        req = '0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check({25'h0, pin_oe}, 32'h0);
        rdc(A_PERIOD, PERIOD_RST, 2'b00);
        rdc(A_LOWCYC, LOWCYC_RST, 2'b00);
        rdc(8'h28, 32'h0, 2'b10);
        wr(A_FUNC, 32'h1555);
        repeat (4) @(posedge aclk);
        rdc(A_INVAL, 32'h7f, 2'b00);
        ext_oe <= 7'h04;
        repeat (4) @(posedge aclk);
        rdc(A_INVAL, 32'h7b, 2'b00);
        wr(A_INV, 32'h7f);
        repeat (4) @(posedge aclk);
        rdc(A_INVAL, 32'h04, 2'b00);
        ext_oe <= 7'h0;
        wr(A_INV, 32'h0);
        wr(A_FUNC, 32'h2aa9);
        wr(A_OVAL, 32'h7e);
        pins(7'h7e, 7'h00);
        wr(A_INV, 32'h7e);
        pins(7'h7e, 7'h7e);
        wr(A_OVAL, 32'h0);
        pins(7'h7e, 7'h00);
        wr(A_INV, 32'h0);
        wr(A_PERIOD, 32'ha);
        wr(A_LOWCYC, 32'h3);
        wr(A_PWMEN, 32'h2);
        n = 0;
        repeat (40) begin
            @(negedge aclk);
            if (pin_o[1] === 1'b0) n++;
        end
        @(posedge aclk);
        check(n, 12);
        wr(A_PWMEN, 32'h0);
        wr(A_FUNC, 32'h1554);
        wr(A_MASK, 32'h3);
        rdc(A_STAT, 32'h0, 2'b00);
        prot_active <= 1'b1;
        pulse(ML - 2);
        check(clr_cnt, 0);
        pulse(ML + 2);
        check(clr_cnt, 1);
        check({31'h0, irq}, 32'h1);
        rdc(A_STAT, 32'h1, 2'b00);
        rdc(A_STAT, 32'h0, 2'b00);
        check({31'h0, irq}, 32'h0);
        prot_active <= 1'b0;
        pulse(ML + 2);
        check(clr_cnt, 1);
        out_enable <= 1'b1;
        repeat (3 * ML) @(posedge aclk);
        check({24'h0, pcnt}, 32'h1);
        check({31'h0, plen >= ML}, 32'h1);
        rdc(A_STAT, 32'h2, 2'b00);
        conclude();
    end
endmodule : dio_pin_ctrl_tb
